//--- src/tfe_pkg.sv
package tfe_pkg;

  // ---------------------------------------------------------------
  // Sizes, masks, reset values and grant codes
  // ---------------------------------------------------------------
  localparam int          TFE_WORD_W     = 32;
  localparam int          TFE_FIFO_DEPTH = 32;
  localparam int          TFE_CK_BIT     = 14;
  localparam logic [31:0] TFE_CMDB_MASK  = 32'hffff_bfff;
  localparam logic [31:0] TFE_STAT_RST   = 32'h0000_0000;
  localparam logic [11:0] TFE_SUM_RST    = 12'h000;
  localparam logic [3:0]  TFE_GNT_NONE   = 4'h0;
  localparam logic [3:0]  TFE_GNT_BOUT   = 4'h1;
  localparam logic [3:0]  TFE_GNT_BIN    = 4'h2;
  localparam logic [3:0]  TFE_GNT_MRX    = 4'h4;
  localparam logic [3:0]  TFE_GNT_MTX    = 4'h8;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [13:0] rsvd_hi;
    logic [1:0]  payload_start_offset;
    logic [1:0]  rsvd_mid;
    logic        first_segment_flag;
    logic        last_segment_flag;
    logic        rsvd_lo;
    logic [10:0] buf_size;
  } tfe_cmd_a_t;

  typedef struct packed {
    logic [16:0] rsvd_hi;
    logic        checksum_request_bit;
    logic [1:0]  frame_opts;
    logic        rsvd_lo;
    logic [10:0] frame_len;
  } tfe_cmd_b_t;

  typedef struct packed {
    logic       loss_carrier;
    logic       no_carrier;
    logic       late_coll;
    logic       excess_coll;
    logic [3:0] coll_count;
    logic       excess_defer;
    logic       underrun;
    logic       deferred;
  } tfe_mac_status_t;

  typedef enum logic [2:0] {
    S_CMDA = 3'b000,
    S_CMDB = 3'b001,
    S_DATA = 3'b010,
    S_STAT = 3'b011,
    S_ERR  = 3'b100
  } tfe_state_t;

endpackage

//--- src/tx_frame_extractor.sv
`timescale 1ns/1ps
// Contract
// - Move exactly the frame length bytes of command B to the MAC.
// - Byte enables hide invalid trailing bytes of the last word.
// - First two words of each buffer are commands; data follows.
// - Start offset picks the first valid byte lane, 0 is lowest.
// - Payload contiguous to buffer end; bytes after it are dropped.
// - Any buffer alignment accepted; first and last any length.
// - Strip both commands; adjust enables of first and last words.
// - Command B differs from first buffer, checksum bit aside: error.
// - Completed buffer size sum not equal frame length: error.
// - Missing first flag, or first flag while short: error.
// - Last flag missing when sum reached, or set while short: error.
// - Zero buffer size raises the error flag.
// - Error sets status flag; stalls bulk-out unless disabled.
// - Status bit 15 is OR of bits 11,10,9,8,2,1.
// - Status bits 11,10,9,8,6:3,0 report carrier, collision, deferral.
// - Bit 2 shows excessive deferral only when checking enabled.
// - Underrun sets status bit 1 and the underrun flag.
// - Flush resets FIFO pointers; flush bit clears when done.
// - Halt finishes frame, waits status, clears bits, pulses stop.
// - Setting on and MAC enable resumes with frames still queued.
// - Strict priority: bulk-out, bulk-in, MAC receive, MAC transmit.
// - Command A: offset 17:16, first 13, last 12, size 10:0.
// - Checksum bit needs first flag and engine enable.

// ---------------------------------------------------------------
// Data FIFO
// ---------------------------------------------------------------
module tfe_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       clr_i,
  input  wire logic [WIDTH-1:0]           in_data_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  output logic [WIDTH-1:0]                out_data_o,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [$clog2(DEPTH):0]          level_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             rdy_ff;
  logic             push;
  logic             pop;
  logic [AW:0]      nxt_count;

  assign push        = in_valid_i & rdy_ff & ~clr_i;
  assign pop         = out_ready_i & (count_ff != '0) & ~clr_i;
  assign nxt_count   = clr_i ? '0 :
                       count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready_o  = rdy_ff;
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem[rd_ptr_ff];
  assign level_o     = count_ff;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || clr_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      count_ff <= '0;
      rdy_ff   <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      rdy_ff   <= (nxt_count < (AW+1)'(DEPTH));
    end
  end
endmodule

// ---------------------------------------------------------------
// Frame extractor
// ---------------------------------------------------------------
module tx_frame_extractor #(
  parameter int WIDTH = tfe_pkg::TFE_WORD_W,
  parameter int DEPTH = tfe_pkg::TFE_FIFO_DEPTH
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic [31:0]              wr_data_i,
  input  wire logic                     wr_valid_i,
  output logic                          wr_ready_o,
  input  wire logic                     bulk_in_req_i,
  input  wire logic                     mac_rx_req_i,
  output logic [3:0]                    arb_grant_o,
  output logic [31:0]                   mac_data_o,
  output logic [3:0]                    mac_be_o,
  output logic                          mac_valid_o,
  output logic                          mac_last_o,
  input  wire logic                     mac_ready_i,
  output logic                          checksum_insert_o,
  input  wire tfe_pkg::tfe_mac_status_t mac_status_i,
  input  wire logic                     mac_status_valid_i,
  input  wire logic                     deferral_check_en_i,
  output logic [31:0]                   tx_status_o,
  output logic                          tx_status_valid_o,
  output logic                          tx_path_error_o,
  output logic                          tx_underrun_flag_o,
  input  wire logic                     tx_underrun_clr_i,
  input  wire logic                     bulk_out_stall_disable_i,
  output logic                          bulk_out_stall_o,
  input  wire logic                     tx_checksum_engine_enable_i,
  input  wire logic                     mac_transmit_enable_i,
  input  wire logic                     flush_set_i,
  output logic                          flush_bit_o,
  input  wire logic                     halt_set_i,
  output logic                          halt_req_o,
  input  wire logic                     tx_on_set_i,
  output logic                          tx_on_o,
  output logic                          transmitter_stopped_pulse_o
);
  import tfe_pkg::*;

  tfe_state_t       state_ff;
  tfe_state_t       nxt_state;
  tfe_cmd_a_t       cmda_ff;
  tfe_cmd_b_t       cmdb_ff;
  logic [11:0]      sum_ff;
  logic [10:0]      remain_ff;
  logic             first_word_ff;
  logic             last_buf_ff;
  logic             err_ff;
  logic             stall_ff;
  logic             udr_ff;
  logic             flush_ff;
  logic             halt_ff;
  logic             on_ff;
  logic             stop_ff;
  logic             ck_ff;
  logic [31:0]      stat_ff;
  logic             stat_vld_ff;
  logic [3:0]       gnt_ff;
  logic [31:0]      dat_ff;
  logic [3:0]       be_ff;
  logic             vld_ff;
  logic             last_ff;

  logic [31:0]      fifo_word;
  logic             fifo_vld;
  logic [$clog2(DEPTH):0] fifo_level;
  tfe_cmd_a_t       word_a;
  tfe_cmd_b_t       word_b;

  // ---------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------
  wire bout_req  = wr_valid_i & wr_ready_o;
  wire rd_win    = ~bout_req & ~bulk_in_req_i & ~mac_rx_req_i;
  wire out_free  = ~vld_ff | mac_ready_i;
  wire run_ok    = on_ff & mac_transmit_enable_i & ~halt_ff;
  wire mid_frame = (sum_ff != TFE_SUM_RST);
  wire want      = ((state_ff == S_CMDA) & (mid_frame | run_ok)) |
                   (state_ff == S_CMDB) |
                   ((state_ff == S_DATA) & out_free);
  wire rd_pop    = want & fifo_vld & rd_win & ~flush_ff;
  wire [3:0] nxt_gnt = bout_req      ? TFE_GNT_BOUT :
                       bulk_in_req_i ? TFE_GNT_BIN  :
                       mac_rx_req_i  ? TFE_GNT_MRX  :
                       rd_pop        ? TFE_GNT_MTX  : TFE_GNT_NONE;

  tfe_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .clr_i       (flush_ff),
    .in_data_i   (wr_data_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .out_data_o  (fifo_word),
    .out_valid_o (fifo_vld),
    .out_ready_i (rd_pop),
    .level_o     (fifo_level)
  );

  // ---------------------------------------------------------------
  // Command checks
  // ---------------------------------------------------------------
  assign word_a = tfe_cmd_a_t'(fifo_word);
  assign word_b = tfe_cmd_b_t'(fifo_word);

  wire        b_take   = rd_pop & (state_ff == S_CMDB);
  wire        is_first = ~mid_frame;
  wire [11:0] new_sum  = sum_ff + {1'b0, cmda_ff.buf_size};
  wire [10:0] flen     = is_first ? word_b.frame_len : cmdb_ff.frame_len;
  wire [11:0] flen12   = {1'b0, flen};
  wire        e_zero   = (cmda_ff.buf_size == 11'h000);
  wire        e_fs_mis = is_first & ~cmda_ff.first_segment_flag;
  wire        e_fs_unx = ~is_first & cmda_ff.first_segment_flag;
  wire        e_b      = ~is_first &
                         (((fifo_word ^ cmdb_ff) & TFE_CMDB_MASK) != '0);
  wire        e_ls_mis = (new_sum >= flen12) &
                         ~cmda_ff.last_segment_flag;
  wire        e_ls_unx = cmda_ff.last_segment_flag &
                         (new_sum < flen12);
  wire        e_sum    = cmda_ff.last_segment_flag &
                         (new_sum != flen12);
  wire        cmd_err  = b_take & (e_zero | e_fs_mis | e_fs_unx | e_b |
                                   e_ls_mis | e_ls_unx | e_sum);

  // ---------------------------------------------------------------
  // Byte lanes
  // ---------------------------------------------------------------
  wire [1:0]  lane0    = first_word_ff ?
                         cmda_ff.payload_start_offset : 2'h0;
  wire [2:0]  room     = 3'h4 - {1'b0, lane0};
  wire        short    = (remain_ff < {8'h00, room});
  wire [2:0]  take     = short ? remain_ff[2:0] : room;
  wire [2:0]  lane_end = {1'b0, lane0} + take;
  wire [4:0]  end_mask = (5'h01 << lane_end) - 5'h01;
  wire [3:0]  be       = end_mask[3:0] & (4'hf << lane0);
  wire        buf_done = ({8'h00, take} == remain_ff);
  wire        d_take   = rd_pop & (state_ff == S_DATA);
  wire        stop_now = (state_ff == S_CMDA) & ~mid_frame & halt_ff &
                         ~flush_ff;

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  wire s_take = mac_status_valid_i & (state_ff == S_STAT);
  wire s_def  = mac_status_i.excess_defer & deferral_check_en_i;
  wire s_es   = mac_status_i.loss_carrier | mac_status_i.no_carrier |
                mac_status_i.late_coll | mac_status_i.excess_coll |
                s_def | mac_status_i.underrun;
  wire [31:0] s_word = {16'h0000, s_es, 3'h0,
                        mac_status_i.loss_carrier,
                        mac_status_i.no_carrier,
                        mac_status_i.late_coll,
                        mac_status_i.excess_coll, 1'b0,
                        mac_status_i.coll_count, s_def,
                        mac_status_i.underrun,
                        mac_status_i.deferred};

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_CMDA: if (rd_pop) nxt_state = S_CMDB;
      S_CMDB: if (cmd_err) begin
        nxt_state = S_ERR;
      end else if (b_take) begin
        nxt_state = S_DATA;
      end
      S_DATA: if (d_take && buf_done) begin
        nxt_state = last_buf_ff ? S_STAT : S_CMDA;
      end
      S_STAT: if (s_take) nxt_state = S_CMDA;
      S_ERR:  nxt_state = S_ERR;
      default: nxt_state = S_ERR;
    endcase
    if (flush_ff && state_ff != S_ERR) begin
      nxt_state = S_CMDA;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) state_ff <= S_CMDA;
    else       state_ff <= nxt_state;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmda_ff <= '0;
      cmdb_ff <= '0;
    end else begin
      if (rd_pop && state_ff == S_CMDA) cmda_ff <= word_a;
      if (b_take && is_first)           cmdb_ff <= word_b;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i || flush_ff) begin
      sum_ff        <= TFE_SUM_RST;
      remain_ff     <= 11'h000;
      first_word_ff <= 1'b0;
      last_buf_ff   <= 1'b0;
    end else if (b_take) begin
      sum_ff        <= new_sum;
      remain_ff     <= cmda_ff.buf_size;
      first_word_ff <= 1'b1;
      last_buf_ff   <= cmda_ff.last_segment_flag;
    end else if (d_take) begin
      remain_ff     <= remain_ff - {8'h00, take};
      first_word_ff <= 1'b0;
      if (buf_done && last_buf_ff) sum_ff <= TFE_SUM_RST;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) ck_ff <= 1'b0;
    else if (b_take && is_first) begin
      ck_ff <= word_b.checksum_request_bit &
               cmda_ff.first_segment_flag &
               tx_checksum_engine_enable_i;
    end
  end

  // ---------------------------------------------------------------
  // MAC output stage
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      vld_ff  <= 1'b0;
      dat_ff  <= '0;
      be_ff   <= 4'h0;
      last_ff <= 1'b0;
    end else if (d_take) begin
      vld_ff  <= 1'b1;
      dat_ff  <= fifo_word;
      be_ff   <= be;
      last_ff <= buf_done & last_buf_ff;
    end else if (mac_ready_i) begin
      vld_ff  <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Flags and control bits
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      err_ff   <= 1'b0;
      stall_ff <= 1'b0;
      udr_ff   <= 1'b0;
    end else begin
      err_ff   <= err_ff | cmd_err;
      stall_ff <= err_ff & ~bulk_out_stall_disable_i;
      udr_ff   <= (s_take & mac_status_i.underrun) |
                  (udr_ff & ~tx_underrun_clr_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flush_ff <= 1'b0;
      halt_ff  <= 1'b0;
      on_ff    <= 1'b0;
      stop_ff  <= 1'b0;
    end else begin
      flush_ff <= flush_set_i;
      halt_ff  <= halt_set_i | (halt_ff & ~stop_now);
      on_ff    <= tx_on_set_i | (on_ff & ~stop_now);
      stop_ff  <= stop_now;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      stat_ff     <= TFE_STAT_RST;
      stat_vld_ff <= 1'b0;
      gnt_ff      <= TFE_GNT_NONE;
    end else begin
      if (s_take) stat_ff <= s_word;
      stat_vld_ff <= s_take;
      gnt_ff      <= nxt_gnt;
    end
  end

  assign arb_grant_o                 = gnt_ff;
  assign mac_data_o                  = dat_ff;
  assign mac_be_o                    = be_ff;
  assign mac_valid_o                 = vld_ff;
  assign mac_last_o                  = last_ff;
  assign checksum_insert_o           = ck_ff;
  assign tx_status_o                 = stat_ff;
  assign tx_status_valid_o           = stat_vld_ff;
  assign tx_path_error_o             = err_ff;
  assign tx_underrun_flag_o          = udr_ff;
  assign bulk_out_stall_o            = stall_ff;
  assign flush_bit_o                 = flush_ff;
  assign halt_req_o                  = halt_ff;
  assign tx_on_o                     = on_ff;
  assign transmitter_stopped_pulse_o = stop_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_be_nonzero;
    @(posedge core_clk_i) disable iff (rst_i)
      d_take |=> (mac_be_o != 4'h0);
  endproperty
  a_be_nonzero: assert property (p_be_nonzero)
    else $error("empty byte enable forwarded");

  property p_err_sticky;
    @(posedge core_clk_i) disable iff (rst_i)
      tx_path_error_o |=> tx_path_error_o && state_ff == S_ERR;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag dropped");

  property p_zero_size;
    @(posedge core_clk_i) disable iff (rst_i)
      (b_take && e_zero) |=> tx_path_error_o;
  endproperty
  a_zero_size: assert property (p_zero_size)
    else $error("zero size not flagged");

  property p_fs_missing;
    @(posedge core_clk_i) disable iff (rst_i)
      (b_take && is_first && !cmda_ff.first_segment_flag)
        |=> tx_path_error_o;
  endproperty
  a_fs_missing: assert property (p_fs_missing)
    else $error("missing first flag not flagged");

  property p_sum_mismatch;
    @(posedge core_clk_i) disable iff (rst_i)
      (b_take && cmda_ff.last_segment_flag && new_sum != flen12)
        |=> tx_path_error_o;
  endproperty
  a_sum_mismatch: assert property (p_sum_mismatch)
    else $error("size sum mismatch not flagged");

  property p_stall;
    @(posedge core_clk_i) disable iff (rst_i)
      (tx_path_error_o && !bulk_out_stall_disable_i) |=> bulk_out_stall_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("bulk-out stall missing");

  property p_es_or;
    @(posedge core_clk_i) disable iff (rst_i)
      tx_status_valid_o |->
        tx_status_o[15] == (|{tx_status_o[11:8], tx_status_o[2:1]});
  endproperty
  a_es_or: assert property (p_es_or)
    else $error("status error summary wrong");

  property p_flush;
    @(posedge core_clk_i) disable iff (rst_i)
      flush_set_i |=> flush_bit_o ##1 (fifo_level == '0);
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush left data in fifo");

  property p_stop;
    @(posedge core_clk_i) disable iff (rst_i)
      $rose(transmitter_stopped_pulse_o) |->
        !$past(tx_on_set_i) |-> !tx_on_o ##1 !transmitter_stopped_pulse_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not clear on bit");

  property p_prio;
    @(posedge core_clk_i) disable iff (rst_i)
      bout_req |=> arb_grant_o == TFE_GNT_BOUT;
  endproperty
  a_prio: assert property (p_prio)
    else $error("bulk-out lost priority");
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import tfe_pkg::*;
  logic core_clk_i = 0, rst_i = 1, wr_valid_i = 0, bin = 0, mrx = 0;
  logic slow = 0, dck = 0, uclr = 0, cken = 1, flush = 0, halt = 0, on = 0;
  logic sbd = 0, mten = 1;
  logic [31:0] wr_data_i = 32'h0, tx_status_o;
  logic [3:0]  grant, be;
  logic [31:0] mdata;
  logic mvalid, mlast, mready, ckins, stv, perr, uflag, stall, fbit;
  logic hreq, txon, stopped, wr_ready_o, msv;
  tfe_mac_status_t sti = '0, sto;
  int mismatches = 0, n_checks = 0, cycles = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  tx_frame_extractor dut (.core_clk_i, .rst_i, .wr_data_i, .wr_valid_i,
    .wr_ready_o, .bulk_in_req_i(bin), .mac_rx_req_i(mrx),
    .arb_grant_o(grant), .mac_data_o(mdata), .mac_be_o(be),
    .mac_valid_o(mvalid), .mac_last_o(mlast), .mac_ready_i(mready),
    .checksum_insert_o(ckins), .mac_status_i(sto),
    .mac_status_valid_i(msv), .deferral_check_en_i(dck), .tx_status_o,
    .tx_status_valid_o(stv), .tx_path_error_o(perr),
    .tx_underrun_flag_o(uflag), .tx_underrun_clr_i(uclr),
    .bulk_out_stall_disable_i(sbd), .bulk_out_stall_o(stall),
    .tx_checksum_engine_enable_i(cken), .mac_transmit_enable_i(mten),
    .flush_set_i(flush), .flush_bit_o(fbit), .halt_set_i(halt),
    .halt_req_o(hreq), .tx_on_set_i(on), .tx_on_o(txon),
    .transmitter_stopped_pulse_o(stopped));
  tfe_mac_model mac (.core_clk_i, .rst_i, .mac_data_i(mdata),
    .mac_be_i(be), .mac_valid_i(mvalid), .mac_last_i(mlast),
    .slow_i(slow), .stat_i(sti), .mac_ready_o(mready), .stat_o(sto),
    .stat_valid_o(msv));
  task automatic chk(string nm, logic [36:0] seen, logic [36:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic push(input logic [31:0] w);
    wr_data_i  <= w;
    wr_valid_i <= 1'b1;
    do @(posedge core_clk_i); while (wr_ready_o !== 1'b1);
  endtask
  wire [3:0] evt = {stv, stopped, fbit, perr};
  task automatic pulse(input logic [3:0] m);
    @(posedge core_clk_i) {on, uclr, halt, flush} <= m;
    @(posedge core_clk_i) {on, uclr, halt, flush} <= 4'h0;
  endtask
  task automatic wait_hi(input int k);
    repeat (60) if (evt[k] !== 1'b1) @(negedge core_clk_i);
  endtask
  // ---------------------------------------------------------------
  // Two frames: enables, stripping, status word
  // ---------------------------------------------------------------
  task automatic frames();
    logic [31:0] ca[2] = '{32'h0002_3003, 32'h0003_3005};
    logic [31:0] cb[2] = '{32'h0000_4003, 32'h0000_0005};
    logic [10:0] st[2] = '{11'h119, 11'h006};
    logic [31:0] ex[2] = '{32'h0000_8219, 32'h0000_8002};
    logic [3:0]  b0[2] = '{4'hc, 4'h8};
    logic [3:0]  b1[2] = '{4'h1, 4'hf};
    pulse(4'h8);
    for (int f = 0; f < 2; f++) begin
      @(posedge core_clk_i);
      slow <= f[0];
      sti  <= st[f];
      mac.log_q.delete();
      push(ca[f]);
      push(cb[f]);
      push(32'haabbccdd + f);
      push(32'h11223344);
      wr_valid_i <= 1'b0;
      wait_hi(3);
      chk("words", mac.log_q.size(), 2);
      chk("w0", mac.log_q[0], {1'b0, b0[f], 32'haabbccdd + f});
      chk("w1", mac.log_q[1], {1'b1, b1[f], 32'h11223344});
      chk("status", tx_status_o, ex[f]);
      chk("cksum", ckins, !f);
      chk("underrun", uflag, f);
    end
    pulse(4'h4);
    @(negedge core_clk_i) chk("uclr", uflag, 0);
  endtask
  // ---------------------------------------------------------------
  // Three buffers in one frame, middle one four bytes
  // ---------------------------------------------------------------
  task automatic split();
    logic [31:0] w[10] = '{32'h0001_2002, 32'h0000_0007, 32'hc0de_0001,
                           32'h0003_0004, 32'h0000_4007, 32'hc0de_0002,
                           32'hc0de_0003, 32'h0000_1001, 32'h0000_0007,
                           32'hc0de_0004};
    logic [36:0] ex[4] = '{37'h06_c0de_0001, 37'h08_c0de_0002,
                           37'h07_c0de_0003, 37'h11_c0de_0004};
    @(posedge core_clk_i);
    dck <= 1'b1;
    sti <= 11'h004;
    mac.log_q.delete();
    foreach (w[i]) push(w[i]);
    wr_valid_i <= 1'b0;
    wait_hi(3);
    chk("split words", mac.log_q.size(), 4);
    foreach (ex[i]) chk("split", mac.log_q[i], ex[i]);
    chk("defer", tx_status_o, 32'h0000_8004);
    chk("split err", {perr, ckins}, 2'b00);
  endtask
  // ---------------------------------------------------------------
  // Arbitration, halt, flush, zero-size buffer error
  // ---------------------------------------------------------------
  task automatic arb();
    logic [2:0] rq[3] = '{3'b111, 3'b011, 3'b001};
    logic [3:0] g[3]  = '{TFE_GNT_BOUT, TFE_GNT_BIN, TFE_GNT_MRX};
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk_i);
      {wr_valid_i, bin, mrx} <= rq[i];
      @(posedge core_clk_i);
      {wr_valid_i, bin, mrx} <= 3'b000;
      @(negedge core_clk_i) chk("grant", grant, g[i]);
    end
  endtask
  task automatic stop_flush();
    pulse(4'h2);
    wait_hi(2);
    chk("stopped", {hreq, txon, stopped}, 3'b001);
    arb();
    pulse(4'h1);
    wait_hi(1);
    @(negedge core_clk_i) chk("flush", {fbit, wr_ready_o}, 2'b01);
    chk("level", dut.fifo_level, 0);
  endtask
  task automatic bad_buffer();
    @(posedge core_clk_i) mten <= 1'b0;
    pulse(4'h8);
    push(32'h0000_3000);
    push(32'h0000_0000);
    wr_valid_i <= 1'b0;
    repeat (8) @(negedge core_clk_i);
    chk("gated", {perr, dut.fifo_level}, 7'h02);
    @(posedge core_clk_i) mten <= 1'b1;
    wait_hi(0);
    chk("error", perr, 1);
    repeat (20) @(negedge core_clk_i);
    chk("sticky", {perr, stall, mvalid}, 3'b110);
    @(posedge core_clk_i) sbd <= 1'b1;
    @(posedge core_clk_i);
    @(negedge core_clk_i) chk("nostall", {perr, stall}, 2'b10);
  endtask
  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge core_clk_i)
    if (++cycles == 4000) begin
      mismatches++;
      summarize();
    end
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    frames();
    split();
    stop_flush();
    bad_buffer();
    summarize();
  end
endmodule

//--- verification/tfe_mac_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// MAC transmit partner
// ---------------------------------------------------------------
module tfe_mac_model (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire logic [31:0]              mac_data_i,
  input  wire logic [3:0]               mac_be_i,
  input  wire logic                     mac_valid_i,
  input  wire logic                     mac_last_i,
  input  wire logic                     slow_i,
  input  wire tfe_pkg::tfe_mac_status_t stat_i,
  output logic                          mac_ready_o,
  output tfe_pkg::tfe_mac_status_t      stat_o,
  output logic                          stat_valid_o
);
  import tfe_pkg::*;
  logic [36:0] log_q[$];
  logic [1:0]  wait_ff;
  // Status is only meaningful in its pulse; otherwise show inverse
  assign stat_o = stat_valid_o ? stat_i : ~stat_i;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mac_ready_o  <= 1'b0;
      wait_ff      <= 2'h0;
      stat_valid_o <= 1'b0;
    end else begin
      mac_ready_o  <= slow_i ? ~mac_ready_o : 1'b1;
      stat_valid_o <= (wait_ff == 2'h1);
      if (mac_valid_i && mac_ready_o && mac_last_i) wait_ff <= 2'h2;
      else if (wait_ff != 2'h0) wait_ff <= wait_ff - 2'h1;
    end
  end
  always @(posedge core_clk_i)
    if (!rst_i && mac_valid_i && mac_ready_o)
      log_q.push_back({mac_last_i, mac_be_i, mac_data_i});
endmodule
